// File: inc/dlfs_pkg.sv
package dlfs_pkg;
	// ==========================================
	// apb register map (byte addresses)
	localparam logic [7:0] ADDR_STATUS = 8'h00;
	localparam logic [7:0] ADDR_IRQ_STATUS = 8'h04;
	localparam logic [7:0] ADDR_IRQ_MASK = 8'h08;
	localparam logic [7:0] ADDR_CONTROL = 8'h0C;
	localparam logic [7:0] ADDR_ROLLBACK = 8'h10;
	// ==========================================
	// control register fields
	localparam int CTRL_EN0 = 0;
	localparam int CTRL_EN1 = 1;
	localparam int CTRL_SS_TIED = 2;
	localparam logic [31:0] CTRL_RESET = 32'h0000_0003;
	localparam logic [7:0] IRQ_MASK_RESET = 8'h00;
	// ==========================================
	// event / status bit positions
	localparam int EV_SHORT0 = 0;
	localparam int EV_SHORT1 = 1;
	localparam int EV_OPEN0 = 2;
	localparam int EV_OPEN1 = 3;
	localparam int EV_SET_FAULT = 4;
	localparam int EV_THERM_SD = 5;
	localparam int EV_SINGLE0 = 6;
	localparam int EV_SINGLE1 = 7;
	localparam int NUM_EVENTS = 8;
	// ==========================================
	// timing
	localparam int CLK_HZ = 50_000_000;
	localparam int SLOW_TICK_NS = 1000;
	localparam int SLOW_TICK_CYCLES = (SLOW_TICK_NS * (CLK_HZ / 1_000_000)) / 1000;
	localparam int FILTER_TIME_US = 32;
	localparam int FILTER_TICKS = (FILTER_TIME_US * 1000) / SLOW_TICK_NS;
	// ==========================================
	// thermal constants
	localparam logic [7:0] TEMP_ROLLBACK = 8'h91;   // 145 C
	localparam logic [7:0] TEMP_SHUTDOWN = 8'hA5;   // 165 C
	localparam logic [7:0] TEMP_RESTART = 8'h8C;    // 140 C
	localparam logic [7:0] ROLLBACK_GAIN = 8'h31;   // 49
	// ==========================================
	// channel drive states
	typedef enum logic [3:0] {
		DLFS_DRV_OFF = 4'b0001,
		DLFS_DRV_FULL = 4'b0010,
		DLFS_DRV_RECOVER = 4'b0100,
		DLFS_DRV_ROLLBACK = 4'b1000
	} dlfs_drive_t;
	// raw analog comparator results for one channel
	typedef struct packed {
		logic out_below_short;
		logic out_above_short_hy;
		logic head_below_short;
		logic head_below_open;
		logic head_above_open_hy;
		logic st_below;
		logic st_above_hy;
		logic set_pin_bad;
	} dlfs_comp_t;
endpackage

// File: rtl/dlfs_tick.sv
`timescale 1ns/1ps
`default_nettype none
module dlfs_tick import dlfs_pkg::*; #(
	parameter int DIV = SLOW_TICK_CYCLES
) (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// slow enable pulse
	output logic tick
);
	logic [15:0] cnt;
	// ==========================================
	// divider for the slow persistence clock
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt <= 16'h0000;
			tick <= 1'b0;
		end else if (cnt == 16'(DIV - 1)) begin
			cnt <= 16'h0000;
			tick <= 1'b1;
		end else begin
			cnt <= cnt + 16'h0001;
			tick <= 1'b0;
		end
	end
endmodule
`default_nettype wire

// File: rtl/dlfs_filter.sv
`timescale 1ns/1ps
`default_nettype none
module dlfs_filter import dlfs_pkg::*; #(
	parameter int TICKS = FILTER_TICKS
) (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	input wire logic tick,
	// raw condition and release
	input wire logic raw,
	input wire logic release_ok,
	// qualified fault
	output logic fault
);
	logic [15:0] cnt;
	// ==========================================
	// persistence counter restarts
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt <= 16'h0000;
		end else if (!raw || fault) begin
			cnt <= 16'h0000;
		end else if (tick && cnt != 16'(TICKS)) begin
			cnt <= cnt + 16'h0001;
		end
	end
	// qualify after filter time, release on hysteresis
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			fault <= 1'b0;
		end else if (!fault && raw && cnt == 16'(TICKS)) begin
			fault <= 1'b1;
		end else if (fault && release_ok) begin
			fault <= 1'b0;
		end
	end
endmodule
`default_nettype wire

// File: rtl/dlfs_supervisor.sv
`timescale 1ns/1ps
`default_nettype none
// Operation
// - short qualified when output or headroom low for filter time
// - short channel goes to 4mA recovery, other channel off
// - any short, open, set-pin or thermal fault pulls fault flag low
// - short clears above threshold plus hysteresis, normal drive returns
// - open qualified on low headroom for filter time; 4mA, other off
// - open clears above open threshold plus hysteresis
// - set-pin open or short turns both channels off with fault flag
// - any driver holding shared fault line low turns off every channel not in 4mA recovery
// - between rollback and shutdown temps, current drops by 49 per degree over resistor
// - above shutdown temperature both channels off and fault flag low
// - in thermal shutdown enables ignored until below restart temperature
// - single-short sense low drives single-short flag, normal sourcing kept
// - single-short flag tied to fault line: healthy off, faulty at 4mA
// - single-short qualified only after filter time
module dlfs_supervisor import dlfs_pkg::*; #(
	parameter int FILTER = FILTER_TICKS,
	parameter int TICK_DIV = SLOW_TICK_CYCLES
) (
	// apb slave
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// analog comparator results per channel
	input wire logic [1:0] channel_enable_pin,
	input wire dlfs_comp_t comp0,
	input wire dlfs_comp_t comp1,
	input wire logic [7:0] die_temp,
	// shared open-drain fault line (oe low = driving low)
	input wire logic fault_flag_n_in,
	output logic fault_flag_n_out,
	output logic fault_flag_n_oe_n,
	// single-short open-drain flag
	input wire logic single_short_flag_n_in,
	output logic single_short_flag_n_out,
	output logic single_short_flag_n_oe_n,
	// channel drive
	output dlfs_drive_t drive0,
	output dlfs_drive_t drive1,
	output logic [7:0] rollback_step,
	// interrupt
	output logic irq
);
	logic tick;
	logic [1:0] short_q;
	logic [1:0] open_q;
	logic [1:0] single_q;
	logic [1:0] set_bad;
	logic therm_sd;
	logic [31:0] ctrl;
	logic [7:0] irq_status;
	logic [7:0] irq_mask;
	logic [7:0] events;
	logic [7:0] ev_prev;
	logic own_fault;
	logic line_low;
	logic ss_tied_low;
	logic [1:0] en;
	logic in_rollback;
	logic [15:0] rb_calc;
	dlfs_comp_t comp [2];
	logic apb_wr;
	logic apb_rd;
	dlfs_drive_t next_drive0;
	dlfs_drive_t next_drive1;

	assign comp[0] = comp0;
	assign comp[1] = comp1;

	// ==========================================
	// slow persistence enable
	dlfs_tick #(
		.DIV(TICK_DIV)
	) u_tick (
		.pclk(pclk),
		.presetn(presetn),
		.tick(tick)
	);

	// ==========================================
	// per-channel fault filters
	// a qualified fault latches until its own release comparator reports the hysteresis level,
	// so a pin hovering on a threshold cannot make the flag chatter
	for (genvar c = 0; c < 2; c++) begin : g_ch
		dlfs_filter #(
			.TICKS(FILTER)
		) u_short (
			.pclk(pclk),
			.presetn(presetn),
			.tick(tick),
			.raw(comp[c].out_below_short | comp[c].head_below_short),
			.release_ok(comp[c].out_above_short_hy),
			.fault(short_q[c])
		);
		dlfs_filter #(
			.TICKS(FILTER)
		) u_open (
			.pclk(pclk),
			.presetn(presetn),
			.tick(tick),
			.raw(comp[c].head_below_open),
			.release_ok(comp[c].head_above_open_hy),
			.fault(open_q[c])
		);
		dlfs_filter #(
			.TICKS(FILTER)
		) u_single (
			.pclk(pclk),
			.presetn(presetn),
			.tick(tick),
			.raw(comp[c].st_below),
			.release_ok(comp[c].st_above_hy),
			.fault(single_q[c])
		);
		assign set_bad[c] = comp[c].set_pin_bad;
	end

	// ==========================================
	// thermal shutdown with restart hysteresis
	// the gap between shutdown and restart levels stops the channels cycling at the trip point
	// shutdown entry
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			therm_sd <= 1'b0;
		end else if (die_temp > TEMP_SHUTDOWN) begin
			therm_sd <= 1'b1;
		end else if (die_temp < TEMP_RESTART) begin
			therm_sd <= 1'b0;
		end
	end

	assign in_rollback = (die_temp >= TEMP_ROLLBACK) && !therm_sd;
	assign rb_calc = 16'(die_temp - TEMP_ROLLBACK) * 16'(ROLLBACK_GAIN);
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rollback_step <= 8'h00;
		end else if (in_rollback) begin
			rollback_step <= (rb_calc > 16'h00FF) ? 8'hFF : rb_calc[7:0];
		end else begin
			rollback_step <= 8'h00;
		end
	end

	// ==========================================
	// fault flags
	// own faults pull flag low
	assign own_fault = (|short_q) | (|open_q) | (|set_bad) | therm_sd;
	assign fault_flag_n_out = 1'b0;
	// a tied single-short flag holds the shared line low too, so parallel drivers shut down
	assign fault_flag_n_oe_n = !(own_fault | ss_tied_low);
	assign single_short_flag_n_out = 1'b0;
	assign single_short_flag_n_oe_n = !(|single_q);
	assign line_low = !fault_flag_n_in;
	assign ss_tied_low = ctrl[CTRL_SS_TIED] && (|single_q);
	assign en = therm_sd ? 2'b00 : (channel_enable_pin & ctrl[CTRL_EN1:CTRL_EN0]);

	// ==========================================
	// drive state selection
	// priority: blocked, own fault, other fault, tied single short, shared line, rollback, full;
	// every input arrives as an argument so the combinational process sees all it depends on
	function automatic dlfs_drive_t pick(
			input logic en_c,
			input logic blocked,
			input logic self_f,
			input logic other_f,
			input logic tied,
			input logic single_self,
			input logic line,
			input logic roll);
		dlfs_drive_t d;
		d = DLFS_DRV_OFF;
		if (!en_c || blocked) begin
			d = DLFS_DRV_OFF;
		end else if (self_f) begin
			d = DLFS_DRV_RECOVER;
		end else if (other_f) begin
			d = DLFS_DRV_OFF;
		end else if (tied) begin
			d = single_self ? DLFS_DRV_RECOVER : DLFS_DRV_OFF;
		end else if (line) begin
			d = DLFS_DRV_OFF;
		end else if (roll) begin
			d = DLFS_DRV_ROLLBACK;
		end else begin
			d = DLFS_DRV_FULL;
		end
		return d;
	endfunction

	always_comb begin
		next_drive0 = pick(en[0], therm_sd | (|set_bad), short_q[0] | open_q[0], short_q[1] | open_q[1],
			ss_tied_low, single_q[0], line_low, in_rollback);
		next_drive1 = pick(en[1], therm_sd | (|set_bad), short_q[1] | open_q[1], short_q[0] | open_q[0],
			ss_tied_low, single_q[1], line_low, in_rollback);
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			drive0 <= DLFS_DRV_OFF;
			drive1 <= DLFS_DRV_OFF;
		end else begin
			drive0 <= next_drive0;
			drive1 <= next_drive1;
		end
	end

	// ==========================================
	// event capture (rising edge of each qualified fault)
	assign events = {single_q, therm_sd, |set_bad, open_q, short_q};
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ev_prev <= 8'h00;
		end else begin
			ev_prev <= events;
		end
	end

	// ==========================================
	// apb slave, zero wait state
	assign apb_wr = psel && penable && pwrite;
	assign apb_rd = psel && !pwrite;
	assign pready = 1'b1;
	assign pslverr = 1'b0;

	// sticky status, set wins over write-one-clear
	// an event landing in the same cycle as a clear keeps its bit, so no event is lost
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_status <= 8'h00;
		end else if (apb_wr && paddr == ADDR_IRQ_STATUS) begin
			irq_status <= (irq_status & ~pwdata[7:0]) | (events & ~ev_prev);
		end else begin
			irq_status <= irq_status | (events & ~ev_prev);
		end
	end
	// mask and control registers
	// only the three defined control bits are kept, the rest read back as zero
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_mask <= IRQ_MASK_RESET;
			ctrl <= CTRL_RESET;
		end else if (apb_wr) begin
			if (paddr == ADDR_IRQ_MASK) begin
				irq_mask <= pwdata[7:0];
			end
			if (paddr == ADDR_CONTROL) begin
				ctrl <= {29'h0, pwdata[2:0]};
			end
		end
	end
	assign irq = |(irq_status & irq_mask);

	// read data, registered at setup
	// loading at setup lets the word already stand in the access phase with no wait state
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
		end else if (apb_rd && !penable) begin
			case (paddr)
				ADDR_STATUS: begin
					prdata <= {24'h0, events};
				end
				ADDR_IRQ_STATUS: begin
					prdata <= {24'h0, irq_status};
				end
				ADDR_IRQ_MASK: begin
					prdata <= {24'h0, irq_mask};
				end
				ADDR_CONTROL: begin
					prdata <= ctrl;
				end
				ADDR_ROLLBACK: begin
					prdata <= {16'h0, drive1, drive0, rollback_step};
				end
				default: begin
					prdata <= 32'h0000_0000;
				end
			endcase
		end
	end
endmodule
`default_nettype wire

// File: tb/dlfs_line_model.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// shared fault line with pull-ups and a parallel driver
module dlfs_line_model (
	// open-drain enables, low = pulling
	input wire logic fault_oe_n,
	input wire logic single_oe_n,
	// another driver on the shared line
	input wire logic other_pull,
	// resolved line levels
	output logic fault_flag_n,
	output logic single_flag_n
);
	assign fault_flag_n = fault_oe_n & !other_pull;
	// pull-up when released
	assign single_flag_n = single_oe_n;
endmodule
`default_nettype wire

// File: tb/dlfs_supervisor_sva.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// fault supervisor checker
module dlfs_supervisor_sva import dlfs_pkg::*; #(
	parameter int FILTER = FILTER_TICKS,
	parameter int TICK_DIV = SLOW_TICK_CYCLES
) (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// watched signals
	input wire logic [1:0] channel_enable_pin,
	input wire dlfs_comp_t comp0,
	input wire dlfs_comp_t comp1,
	input wire logic [7:0] die_temp,
	input wire logic fault_flag_n_in,
	input wire logic fault_flag_n_oe_n,
	input wire logic single_short_flag_n_oe_n,
	input wire dlfs_drive_t drive0,
	input wire dlfs_drive_t drive1,
	input wire logic [7:0] rollback_step
);
	localparam int QUAL = (FILTER + 1) * TICK_DIV + 4;
	logic [15:0] ns;
	logic [15:0] nt;
	logic s0;
	assign s0 = comp0.out_below_short & !comp0.out_above_short_hy;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// cycles of raw short on channel 0
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) ns <= 16'h0000;
		else ns <= s0 ? ns + {15'h0000, ns != 16'hFFFF} : 16'h0000;
	end
	// cycles of single-short sense low on channel 0
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) nt <= 16'h0000;
		else nt <= comp0.st_below ? nt + {15'h0000, nt != 16'hFFFF} : 16'h0000;
	end
	a_therm_flag: assert property ((die_temp > TEMP_SHUTDOWN)[*2] |-> !fault_flag_n_oe_n)
		else $error("thermal shutdown without fault flag");
	a_therm_off: assert property ((die_temp > TEMP_SHUTDOWN)[*3] |-> drive0 == DLFS_DRV_OFF && drive1 == DLFS_DRV_OFF)
		else $error("channel on in thermal shutdown");
	a_enable_off: assert property (!channel_enable_pin[0] [*3] |-> drive0 == DLFS_DRV_OFF)
		else $error("disabled channel driven");
	a_line_off: assert property ((!fault_flag_n_in && fault_flag_n_oe_n)[*3] |-> drive0 != DLFS_DRV_FULL)
		else $error("full drive while shared line low");
	a_rollback_step: assert property ((die_temp == 8'h96 && fault_flag_n_oe_n)[*2] |-> rollback_step == 8'hF5)
		else $error("rollback step wrong");
	a_filter_wait: assert property ($rose(s0) && fault_flag_n_oe_n && die_temp < TEMP_ROLLBACK |-> fault_flag_n_oe_n[*2])
		else $error("short qualified too early");
	a_short_flag: assert property (ns == QUAL |-> !fault_flag_n_oe_n)
		else $error("short not qualified in filter time");
	a_short_drive: assert property (ns == QUAL && channel_enable_pin == 2'b11 && !comp0.set_pin_bad
		&& !comp1.set_pin_bad && !comp1.out_below_short && !comp1.head_below_short && !comp1.head_below_open
		&& $past(die_temp, 4) < TEMP_RESTART |-> drive0 == DLFS_DRV_RECOVER && drive1 == DLFS_DRV_OFF)
		else $error("short channel drive wrong");
	a_single_flag: assert property (nt == QUAL |-> !single_short_flag_n_oe_n)
		else $error("single short flag not raised");
endmodule
bind dlfs_supervisor dlfs_supervisor_sva #(.FILTER(FILTER), .TICK_DIV(TICK_DIV)) u_sva (.pclk(pclk),
	.presetn(presetn), .channel_enable_pin(channel_enable_pin), .comp0(comp0), .comp1(comp1),
	.die_temp(die_temp), .fault_flag_n_in(fault_flag_n_in), .fault_flag_n_oe_n(fault_flag_n_oe_n),
	.single_short_flag_n_oe_n(single_short_flag_n_oe_n), .drive0(drive0), .drive1(drive1),
	.rollback_step(rollback_step));
`default_nettype wire

// File: tb/dual_led_fault_supervisor_tb.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// bench top
module dual_led_fault_supervisor_tb import dlfs_pkg::*;;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pull = 0;
	logic [7:0] paddr = 8'h00, die_temp = 8'h19, step;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic [1:0] en_pin = 2'b11;
	logic pready, pslverr, irq, ffoe, ssoe, ff_n, ss_n;
	dlfs_comp_t c0 = '0, c1 = '0;
	dlfs_drive_t d0, d1;
	int bad_count = 0, check_count = 0, cyc = 0;
	// clock
	always #10 pclk = ~pclk;
	dlfs_supervisor #(.FILTER(3), .TICK_DIV(2)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .channel_enable_pin(en_pin), .comp0(c0), .comp1(c1),
		.die_temp(die_temp), .fault_flag_n_in(ff_n), .fault_flag_n_out(), .fault_flag_n_oe_n(ffoe),
		.single_short_flag_n_in(ss_n), .single_short_flag_n_out(), .single_short_flag_n_oe_n(ssoe),
		.drive0(d0), .drive1(d1), .rollback_step(step), .irq(irq));
	dlfs_line_model line (.fault_oe_n(ffoe), .single_oe_n(ssoe), .other_pull(pull),
		.fault_flag_n(ff_n), .single_flag_n(ss_n));
	// compare and count
	task chk(input string n, input logic [31:0] e, input logic [31:0] g);
		check_count++;
		if (g !== e) begin
			bad_count++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, g);
		end
	endtask
	// one apb transfer
	task xf(input int w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1;
		pwrite <= w[0];
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1;
		do @(posedge pclk); while (pready !== 1);
		rd = prdata;
		psel <= 0;
		penable <= 0;
		@(posedge pclk);
	endtask
	// wait for both drives, then judge drives and shared line
	task wd(input logic [3:0] e0, input logic [3:0] e1, input logic [31:0] f);
		int i;
		repeat (2) @(posedge pclk);
		for (i = 0; i < 60 && !(d0 === e0 && d1 === e1); i++) @(posedge pclk);
		@(posedge pclk);
		chk("drive0", {28'h0, e0}, {28'h0, d0});
		chk("drive1", {28'h0, e1}, {28'h0, d1});
		chk("fault line", f, {31'h0, ff_n});
	endtask
	// register reset values and unmapped place
	task t_regs;
		xf(0, ADDR_CONTROL, 0);
		chk("control", CTRL_RESET, rd);
		xf(0, ADDR_IRQ_MASK, 0);
		chk("mask", 32'h0, rd);
		xf(1, 8'h40, 32'hFFFFFFFF);
		xf(0, 8'h40, 0);
		chk("unmapped", 32'h0, rd);
		chk("slverr", 32'h0, {31'h0, pslverr});
		xf(0, ADDR_ROLLBACK, 0);
		chk("drive reg", 32'h2200, rd);
		xf(1, ADDR_CONTROL, 32'h1);
		wd(DLFS_DRV_FULL, DLFS_DRV_OFF, 1);
		xf(1, ADDR_CONTROL, 32'h3);
		wd(DLFS_DRV_FULL, DLFS_DRV_FULL, 1);
	endtask
	// output short, irq, release
	task t_short;
		xf(1, ADDR_IRQ_MASK, 32'h1);
		c0.out_below_short <= 1;
		wd(DLFS_DRV_RECOVER, DLFS_DRV_OFF, 0);
		chk("irq", 32'h1, {31'h0, irq});
		xf(0, ADDR_STATUS, 0);
		chk("status", 32'h1, rd);
		xf(0, ADDR_ROLLBACK, 0);
		chk("drive reg short", 32'h1400, rd);
		c0.out_below_short <= 0;
		c0.out_above_short_hy <= 1;
		wd(DLFS_DRV_FULL, DLFS_DRV_FULL, 1);
		xf(0, ADDR_IRQ_STATUS, 0);
		chk("sticky", 32'h1, rd & 32'hFF);
		xf(1, ADDR_IRQ_STATUS, 32'h1);
		chk("irq clear", 32'h0, {31'h0, irq});
		c0.out_above_short_hy <= 0;
	endtask
	// short pulses shorter than filter
	task t_glitch;
		repeat (5) begin
			c0.head_below_short <= 1;
			repeat (4) @(posedge pclk);
			c0.head_below_short <= 0;
			@(posedge pclk);
		end
		chk("glitch line", 32'h1, {31'h0, ff_n});
	endtask
	// open, set pin, shared line, thermal
	task t_faults;
		c1.head_below_open <= 1;
		wd(DLFS_DRV_OFF, DLFS_DRV_RECOVER, 0);
		chk("irq masked", 32'h0, {31'h0, irq});
		c1.head_below_open <= 0;
		c1.head_above_open_hy <= 1;
		wd(DLFS_DRV_FULL, DLFS_DRV_FULL, 1);
		c1.head_above_open_hy <= 0;
		c1.set_pin_bad <= 1;
		wd(DLFS_DRV_OFF, DLFS_DRV_OFF, 0);
		c1.set_pin_bad <= 0;
		wd(DLFS_DRV_FULL, DLFS_DRV_FULL, 1);
		pull <= 1;
		wd(DLFS_DRV_OFF, DLFS_DRV_OFF, 0);
		pull <= 0;
		wd(DLFS_DRV_FULL, DLFS_DRV_FULL, 1);
		die_temp <= 8'h96;
		wd(DLFS_DRV_ROLLBACK, DLFS_DRV_ROLLBACK, 1);
		chk("step", 32'hF5, {24'h0, step});
		die_temp <= 8'hAA;
		wd(DLFS_DRV_OFF, DLFS_DRV_OFF, 0);
		die_temp <= 8'h8D;
		en_pin <= 2'b00;
		repeat (3) @(posedge pclk);
		en_pin <= 2'b11;
		wd(DLFS_DRV_OFF, DLFS_DRV_OFF, 0);
		die_temp <= 8'h8B;
		wd(DLFS_DRV_FULL, DLFS_DRV_FULL, 1);
	endtask
	// single short, then tied to shared line
	task t_single;
		int i;
		c0.st_below <= 1;
		for (i = 0; i < 60 && ss_n !== 0; i++) @(posedge pclk);
		chk("single flag", 32'h0, {31'h0, ss_n});
		wd(DLFS_DRV_FULL, DLFS_DRV_FULL, 1);
		xf(1, ADDR_CONTROL, 32'h7);
		wd(DLFS_DRV_RECOVER, DLFS_DRV_OFF, 0);
		c0.st_below <= 0;
		c0.st_above_hy <= 1;
		xf(1, ADDR_CONTROL, 32'h3);
		wd(DLFS_DRV_FULL, DLFS_DRV_FULL, 1);
		chk("single clear", 32'h1, {31'h0, ss_n});
	endtask
	// verdict
	task complete_run;
		$display("checks %0d mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	// hang guard
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 8000) begin
			bad_count++;
			complete_run;
		end
	end
	// main sequence
	initial begin
		repeat (3) @(posedge pclk);
		presetn <= 1;
		@(posedge pclk);
		t_regs;
		$display("regs done");
		t_short;
		$display("short done");
		t_glitch;
		$display("glitch done");
		t_faults;
		$display("faults done");
		t_single;
		$display("single done");
		complete_run;
	end
endmodule
`default_nettype wire
